// *** design/ddr_seq_pkg.sv ***
`default_nettype none

package ddr_seq_pkg;

    localparam int COL_W = 8;
    localparam int DATA_W = 32;
    localparam int BANKS = 4;
    localparam int BA_W = 2;
    localparam int ADDR_W = 12;
    localparam int AUTO_PRE_BIT = 8;

    // timing, in ns as specified, converted to system clock cycles
    localparam int CLK_PERIOD_NS = 100;
    localparam int ACTIVE_MIN_TIME_NS = 40;
    localparam int PRECHARGE_PERIOD_NS = 15;

    function automatic int round_up(input int t, input int p);
        int c;
        c = (t + p - 1) / p;
        return (c < 1) ? 1 : c;
    endfunction

    localparam logic [3:0] ACTIVE_MIN_CYC = 4'(round_up(ACTIVE_MIN_TIME_NS, CLK_PERIOD_NS));
    localparam logic [3:0] PRECHARGE_CYC = 4'(round_up(PRECHARGE_PERIOD_NS, CLK_PERIOD_NS));
    localparam logic [3:0] CNT_SAT = 4'hF;

    // mode settings
    localparam logic [2:0] BL_CODE_2 = 3'h1;
    localparam logic [2:0] BL_CODE_4 = 3'h2;
    localparam logic [2:0] BL_CODE_8 = 3'h3;
    localparam logic [1:0] LAT_THREE = 2'h3;
    localparam logic [3:0] PAIR_STEP = 4'h2;
    localparam logic [3:0] WR_WIN_EXTRA = 4'h2;

    // {ras_n, cas_n, we_n} with chip select active
    typedef enum logic [2:0] {
        CMD_ACT = 3'h3,
        CMD_READ = 3'h5,
        CMD_WRITE = 3'h4,
        CMD_PRE = 3'h2,
        CMD_STOP = 3'h6,
        CMD_NOP = 3'h7
    } cmd_e;

    typedef enum logic [1:0] {
        RD_IDLE = 2'h0,
        RD_RUN = 2'h1
    } rd_state_e;

    function automatic logic [3:0] burst_len(input logic [2:0] code);
        case (code)
            BL_CODE_2: return 4'h2;
            BL_CODE_4: return 4'h4;
            BL_CODE_8: return 4'h8;
            default: return 4'h2;
        endcase
    endfunction

    // column of word idx of a burst, sequential or interleaved wrap
    function automatic logic [COL_W-1:0] burst_col(input logic [COL_W-1:0] start, input logic [3:0] idx,
                                                   input logic [3:0] len, input logic ilv);
        logic [COL_W-1:0] m;
        logic [COL_W-1:0] off;
        m = COL_W'(len - 4'h1);
        off = ilv ? (start ^ COL_W'(idx)) : (start + COL_W'(idx));
        return (start & ~m) | (off & m);
    endfunction

endpackage

`default_nettype wire

// *** design/ddr_link_if.sv ***
`default_nettype none

interface ddr_link_if import ddr_seq_pkg::*;;
    logic wr_tgl;
    logic abort_tgl;
    logic [COL_W-1:0] wr_col;
    logic [BA_W-1:0] wr_bank;
    logic [3:0] wr_len;
    logic wr_ilv;

    modport ctrl(output wr_tgl, abort_tgl, wr_col, wr_bank, wr_len, wr_ilv);
    modport link(input wr_tgl, abort_tgl, wr_col, wr_bank, wr_len, wr_ilv);
endinterface

`default_nettype wire

// *** design/ddr_write_capture.sv ***
`default_nettype none

module ddr_write_capture import ddr_seq_pkg::*; (
    input wire logic i_strobe_clk,
    input wire logic i_reset,
    ddr_link_if.link lk,
    input wire logic [DATA_W-1:0] i_dq,
    input wire logic i_write_mask,
    output logic o_wr_en,
    output logic [BA_W-1:0] o_wr_bank,
    output logic [COL_W-1:0] o_wr_col,
    output logic [DATA_W-1:0] o_wr_data
);

    logic [2:0] wr_s_q;
    logic [2:0] ab_s_q;
    logic new_wr;
    logic abort;
    logic active_q;
    logic [3:0] idx_q;
    logic [3:0] len_q;
    logic [COL_W-1:0] start_q;
    logic ilv_q;

    // toggle synchronisers; stage 0 feeds stage 1 only
    always_ff @(posedge i_strobe_clk or posedge i_reset) begin
        if (i_reset) begin
            wr_s_q <= 3'h0;
            ab_s_q <= 3'h0;
        end else begin
            wr_s_q <= {wr_s_q[1:0], lk.wr_tgl};
            ab_s_q <= {ab_s_q[1:0], lk.abort_tgl};
        end
    end

    assign new_wr = wr_s_q[2] ^ wr_s_q[1];
    assign abort = ab_s_q[2] ^ ab_s_q[1];

    always_ff @(posedge i_strobe_clk or posedge i_reset) begin
        if (i_reset) begin
            active_q <= 1'b0;
            idx_q <= 4'h0;
            len_q <= 4'h2;
            start_q <= '0;
            ilv_q <= 1'b0;
            o_wr_en <= 1'b0;
            o_wr_bank <= '0;
            o_wr_col <= '0;
            o_wr_data <= '0;
        end else begin
            o_wr_en <= 1'b0;
            if (new_wr) begin
                // fields are quiet once the toggle is seen
                active_q <= 1'b1;
                idx_q <= 4'h0;
                len_q <= lk.wr_len;
                start_q <= lk.wr_col;
                ilv_q <= lk.wr_ilv;
                o_wr_bank <= lk.wr_bank;
            end else if (abort) begin
                active_q <= 1'b0;
            end else if (active_q) begin
                o_wr_en <= ~i_write_mask;
                o_wr_col <= burst_col(start_q, idx_q, len_q, ilv_q);
                o_wr_data <= i_dq;
                idx_q <= idx_q + 4'h1;
                if (idx_q + 4'h1 == len_q) begin
                    active_q <= 1'b0;
                end
            end
        end
    end

    chk_past_burst_end: assert property (@(posedge i_strobe_clk) disable iff (i_reset)
        !active_q |=> !o_wr_en) else $error("write stored outside a burst");
    chk_mask_blocks_word: assert property (@(posedge i_strobe_clk) disable iff (i_reset)
        (active_q && i_write_mask && !new_wr && !abort) |=> !o_wr_en) else $error("masked word stored");
    chk_abort_ends_burst: assert property (@(posedge i_strobe_clk) disable iff (i_reset)
        (abort && !new_wr) |=> (!active_q && !o_wr_en) ##1 !o_wr_en) else $error("write not stopped by read");

endmodule

`default_nettype wire

// *** design/ddr_burst_seq.sv ***
`default_nettype none

// Summary of operation
// - read taken at rising edge, start column
// - burst type and length from mode
// - read data after latency, words follow
// - write taken at rising edge, start column
// - words captured until length, extra ignored
// - new read restarts full burst
// - old data until new latency; spacing
// - precharge cuts read; outputs off later
// - truncated read ends, outputs tristate
// - auto precharge at earliest clean point
// - precharge waits active minimum time (code drops an explicit precharge issued before it)
// - new write restarts write burst
// - words before read still stored
// - strobes of masked words ignored
// - burst stop tristates after latency (code ignores burst stop during an auto-precharge read)
// - write mask blocks the word
module ddr_burst_seq import ddr_seq_pkg::*; (
    input wire logic i_mclk,
    input wire logic i_reset,
    input wire logic i_ce,
    input wire logic i_strobe_clk,
    input wire logic i_cs_n,
    input wire logic i_ras_n,
    input wire logic i_cas_n,
    input wire logic i_we_n,
    input wire logic [BA_W-1:0] i_ba,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [2:0] i_burst_len_code,
    input wire logic i_burst_interleave,
    input wire logic [1:0] i_column_latency,
    input wire logic [DATA_W-1:0] i_rd_data_even,
    input wire logic [DATA_W-1:0] i_rd_data_odd,
    input wire logic [DATA_W-1:0] i_dq,
    input wire logic i_write_mask,
    output logic o_rd_req,
    output logic [BA_W-1:0] o_rd_bank,
    output logic [COL_W-1:0] o_rd_col_even,
    output logic [COL_W-1:0] o_rd_col_odd,
    output logic [DATA_W-1:0] o_dq_even,
    output logic [DATA_W-1:0] o_dq_odd,
    output logic o_dq_oe,
    output logic o_wr_en,
    output logic [BA_W-1:0] o_wr_bank,
    output logic [COL_W-1:0] o_wr_col,
    output logic [DATA_W-1:0] o_wr_data,
    output logic [BANKS-1:0] o_bank_open
);

    cmd_e cmd;
    logic [COL_W-1:0] col;
    logic auto_pre;
    logic [3:0] len_now;

    logic [BANKS-1:0] open_q;
    logic [3:0] ras_cnt_q [BANKS];
    logic [3:0] rp_cnt_q [BANKS];

    rd_state_e rd_state_q;
    logic [COL_W-1:0] rd_start_q;
    logic [3:0] rd_idx_q;
    logic [3:0] rd_len_q;
    logic rd_ilv_q;
    logic [BA_W-1:0] rd_bank_q;
    logic rd_ap_q;
    logic iss_v_q;

    logic rd_go;
    logic rd_cut;
    logic rd_step;
    logic rd_end;
    logic ap_set;
    logic ap_fire;
    logic ap_pend_q;
    logic [BA_W-1:0] ap_bank_q;

    logic [1:0] sh_v_q;
    logic [DATA_W-1:0] sh_e_q [2];
    logic [DATA_W-1:0] sh_o_q [2];
    logic out_sel;

    logic [3:0] wr_win_q;
    logic wr_busy;

    ddr_link_if lk();

    // deselect decodes as no-operation
    assign cmd = i_cs_n ? CMD_NOP : cmd_e'({i_ras_n, i_cas_n, i_we_n});
    assign col = i_addr[COL_W-1:0];
    assign auto_pre = i_addr[AUTO_PRE_BIT];
    assign len_now = burst_len(i_burst_len_code);
    assign o_bank_open = open_q;

    // ---- read sequencing decisions
    assign rd_go = (cmd == CMD_READ) && open_q[i_ba];
    assign rd_cut = (rd_state_q == RD_RUN) && !rd_go &&
                    (((cmd == CMD_STOP) && !rd_ap_q) ||
                     ((cmd == CMD_PRE) && (auto_pre || (i_ba == rd_bank_q))));
    assign rd_step = (rd_state_q == RD_RUN) && !rd_go && !rd_cut;
    assign rd_end = rd_go ? (len_now == PAIR_STEP) : (rd_step && (rd_idx_q + PAIR_STEP >= rd_len_q));
    assign ap_set = rd_end && (rd_go ? auto_pre : rd_ap_q);
    assign ap_fire = ap_pend_q && (ras_cnt_q[ap_bank_q] >= ACTIVE_MIN_CYC);

    // ---- bank open/closed and timers
    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            open_q <= '0;
            for (int b = 0; b < BANKS; b++) begin
                ras_cnt_q[b] <= 4'h0;
                rp_cnt_q[b] <= 4'h0;
            end
        end else if (i_ce) begin
            for (int b = 0; b < BANKS; b++) begin
                if (ras_cnt_q[b] != CNT_SAT) begin
                    ras_cnt_q[b] <= ras_cnt_q[b] + 4'h1;
                end
                if (rp_cnt_q[b] != 4'h0) begin
                    rp_cnt_q[b] <= rp_cnt_q[b] - 4'h1;
                end
                if ((cmd == CMD_ACT) && (i_ba == BA_W'(b)) && !open_q[b] && (rp_cnt_q[b] == 4'h0)) begin
                    open_q[b] <= 1'b1;
                    ras_cnt_q[b] <= 4'h0;
                end
                if ((cmd == CMD_PRE) && (auto_pre || (i_ba == BA_W'(b))) && open_q[b] &&
                    (ras_cnt_q[b] >= ACTIVE_MIN_CYC)) begin
                    open_q[b] <= 1'b0;
                    rp_cnt_q[b] <= PRECHARGE_CYC;
                end
                if (ap_fire && (ap_bank_q == BA_W'(b))) begin
                    open_q[b] <= 1'b0;
                    rp_cnt_q[b] <= PRECHARGE_CYC;
                end
            end
        end
    end

    // ---- internal precharge after an auto-precharge read
    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            ap_pend_q <= 1'b0;
            ap_bank_q <= '0;
        end else if (i_ce) begin
            if (ap_set) begin
                // set wins over the clear of an older pending close
                ap_pend_q <= 1'b1;
                ap_bank_q <= rd_go ? i_ba : rd_bank_q;
            end else if (ap_fire) begin
                ap_pend_q <= 1'b0;
            end
        end
    end

    // ---- read column issue, one even/odd pair per clock
    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            rd_state_q <= RD_IDLE;
            rd_start_q <= '0;
            rd_idx_q <= 4'h0;
            rd_len_q <= 4'h2;
            rd_ilv_q <= 1'b0;
            rd_bank_q <= '0;
            rd_ap_q <= 1'b0;
            iss_v_q <= 1'b0;
            o_rd_col_even <= '0;
            o_rd_col_odd <= '0;
        end else if (i_ce) begin
            iss_v_q <= 1'b0;
            if (rd_go) begin
                // an open burst is dropped, the new one runs in full
                rd_start_q <= col;
                rd_len_q <= len_now;
                rd_ilv_q <= i_burst_interleave;
                rd_bank_q <= i_ba;
                rd_ap_q <= auto_pre;
                rd_idx_q <= PAIR_STEP;
                iss_v_q <= 1'b1;
                o_rd_col_even <= burst_col(col, 4'h0, len_now, i_burst_interleave);
                o_rd_col_odd <= burst_col(col, 4'h1, len_now, i_burst_interleave);
                rd_state_q <= (len_now == PAIR_STEP) ? RD_IDLE : RD_RUN;
            end else if (rd_cut) begin
                rd_state_q <= RD_IDLE;
            end else if (rd_step) begin
                iss_v_q <= 1'b1;
                o_rd_col_even <= burst_col(rd_start_q, rd_idx_q, rd_len_q, rd_ilv_q);
                o_rd_col_odd <= burst_col(rd_start_q, rd_idx_q + 4'h1, rd_len_q, rd_ilv_q);
                rd_idx_q <= rd_idx_q + PAIR_STEP;
                if (rd_end) begin
                    rd_state_q <= RD_IDLE;
                end
            end
        end
    end

    assign o_rd_req = iss_v_q;
    assign o_rd_bank = rd_bank_q;

    // ---- output latency pipe; words already issued still drain
    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            sh_v_q <= 2'h0;
            for (int s = 0; s < 2; s++) begin
                sh_e_q[s] <= '0;
                sh_o_q[s] <= '0;
            end
        end else if (i_ce) begin
            sh_v_q <= {sh_v_q[0], iss_v_q};
            sh_e_q[0] <= i_rd_data_even;
            sh_o_q[0] <= i_rd_data_odd;
            sh_e_q[1] <= sh_e_q[0];
            sh_o_q[1] <= sh_o_q[0];
        end
    end

    assign out_sel = (i_column_latency == LAT_THREE);

    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            o_dq_oe <= 1'b0;
            o_dq_even <= '0;
            o_dq_odd <= '0;
        end else if (i_ce) begin
            o_dq_oe <= sh_v_q[out_sel];
            o_dq_even <= sh_e_q[out_sel];
            o_dq_odd <= sh_o_q[out_sel];
        end
    end

    // ---- write commands handed to the strobe domain
    assign wr_busy = (wr_win_q != 4'h0);

    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            lk.wr_tgl <= 1'b0;
            lk.abort_tgl <= 1'b0;
            lk.wr_col <= '0;
            lk.wr_bank <= '0;
            lk.wr_len <= 4'h2;
            lk.wr_ilv <= 1'b0;
            wr_win_q <= 4'h0;
        end else if (i_ce) begin
            if (wr_busy) begin
                wr_win_q <= wr_win_q - 4'h1;
            end
            if ((cmd == CMD_WRITE) && open_q[i_ba]) begin
                lk.wr_tgl <= ~lk.wr_tgl;
                lk.wr_col <= col;
                lk.wr_bank <= i_ba;
                lk.wr_len <= len_now;
                lk.wr_ilv <= i_burst_interleave;
                wr_win_q <= (len_now >> 1) + WR_WIN_EXTRA;
            end else if (rd_go && wr_busy) begin
                // words already taken stay stored, the rest are dropped
                lk.abort_tgl <= ~lk.abort_tgl;
                wr_win_q <= 4'h0;
            end
        end
    end

    ddr_write_capture u_capture (
        .i_strobe_clk(i_strobe_clk),
        .i_reset(i_reset),
        .lk(lk.link),
        .i_dq(i_dq),
        .i_write_mask(i_write_mask),
        .o_wr_en(o_wr_en),
        .o_wr_bank(o_wr_bank),
        .o_wr_col(o_wr_col),
        .o_wr_data(o_wr_data)
    );

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_reset);

    chk_read_closed_bank: assert property (
        (i_ce && (rd_state_q == RD_IDLE) && (cmd == CMD_READ) && !open_q[i_ba]) |=> !iss_v_q)
        else $error("read issued to closed bank");
    chk_read_start_col: assert property (
        (i_ce && rd_go) |=> (iss_v_q && (o_rd_col_even == $past(col))))
        else $error("read start column wrong");
    chk_lat_two: assert property (
        (i_ce && rd_go && (i_column_latency == 2'h2)) ##1 i_ce [*2] |=> o_dq_oe)
        else $error("data missing two clocks after read");
    chk_lat_three: assert property (
        (i_ce && rd_go && (i_column_latency == LAT_THREE)) ##1 i_ce [*3] |=> o_dq_oe)
        else $error("data missing three clocks after read");
    chk_restart_index: assert property (
        (i_ce && rd_go && (rd_state_q == RD_RUN)) |=> (rd_idx_q == PAIR_STEP) && (rd_len_q == $past(len_now)))
        else $error("interrupting read not restarted");
    chk_cut_tristate: assert property (
        (i_ce && rd_cut) ##1 (i_ce && !rd_go) [*3] |=> !o_dq_oe)
        else $error("outputs still driven after burst cut");
    chk_auto_pre_wait: assert property (
        (i_ce && ap_pend_q && (ras_cnt_q[ap_bank_q] < ACTIVE_MIN_CYC)) |=> open_q[$past(ap_bank_q)])
        else $error("auto precharge before active minimum");
    chk_deselect_idle: assert property (
        (i_ce && i_cs_n && !ap_pend_q) |=> (open_q == $past(open_q)))
        else $error("deselect changed bank state");
    chk_write_handoff: assert property (
        (i_ce && (cmd == CMD_WRITE) && open_q[i_ba]) |=> (lk.wr_tgl != $past(lk.wr_tgl)) && (lk.wr_col == $past(col)))
        else $error("write not handed to strobe side");

endmodule

`default_nettype wire

// *** verification/ddr_array_model.sv ***
`default_nettype none

// array behind the sequencer: combinational read, write on strobe clock
module ddr_array_model import ddr_seq_pkg::*; (
    input wire logic i_strobe_clk,
    input wire logic i_wr_en,
    input wire logic [BA_W-1:0] i_wr_bank,
    input wire logic [COL_W-1:0] i_wr_col,
    input wire logic [DATA_W-1:0] i_wr_data,
    input wire logic [BA_W-1:0] i_rd_bank,
    input wire logic [COL_W-1:0] i_rd_col_even,
    input wire logic [COL_W-1:0] i_rd_col_odd,
    output logic [DATA_W-1:0] o_rd_even,
    output logic [DATA_W-1:0] o_rd_odd
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [DATA_W-1:0] mem_q [0:1023];

    initial begin
        for (int i = 0; i < 1024; i++) begin
            mem_q[i] = 32'h5A00_0000 | 32'(i);
        end
    end

    always @(posedge i_strobe_clk) begin
        if (i_wr_en === 1'b1) begin
            mem_q[{i_wr_bank, i_wr_col}] <= i_wr_data;
        end
    end

    assign o_rd_even = mem_q[{i_rd_bank, i_rd_col_even}];
    assign o_rd_odd = mem_q[{i_rd_bank, i_rd_col_odd}];
endmodule

`default_nettype wire

// *** verification/testbench.sv ***
`default_nettype none

module testbench import ddr_seq_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_mclk = 1'b0;
    logic i_reset = 1'b1;
    logic strobe_clk = 1'b0;
    logic i_cs_n = 1'b1, i_ras_n = 1'b1, i_cas_n = 1'b1, i_we_n = 1'b1;
    logic [BA_W-1:0] i_ba = '0;
    logic [ADDR_W-1:0] i_addr = '0;
    logic [2:0] bl_code = 3'h1;
    logic mode_ilv = 1'b0;
    logic [1:0] mode_cl = 2'h2;
    logic [DATA_W-1:0] i_dq = '0;
    logic i_write_mask = 1'b0;
    logic ce = 1'b1;
    logic [DATA_W-1:0] rd_even, rd_odd, o_dq_even, o_dq_odd, o_wr_data;
    logic o_rd_req, o_dq_oe, o_wr_en;
    logic [BA_W-1:0] o_rd_bank, o_wr_bank;
    logic [COL_W-1:0] col_e, col_o, o_wr_col;
    logic [BANKS-1:0] o_bank_open;
    logic [DATA_W-1:0] shadow [0:1023];
    logic [41:0] wq [$];
    int err_count = 0;
    int tests_run = 0;

    initial forever #50 i_mclk = ~i_mclk;

    ddr_burst_seq i_dut (.i_mclk(i_mclk), .i_reset(i_reset), .i_ce(ce), .i_strobe_clk(strobe_clk),
        .i_cs_n(i_cs_n), .i_ras_n(i_ras_n), .i_cas_n(i_cas_n), .i_we_n(i_we_n), .i_ba(i_ba),
        .i_addr(i_addr), .i_burst_len_code(bl_code), .i_burst_interleave(mode_ilv),
        .i_column_latency(mode_cl), .i_rd_data_even(rd_even), .i_rd_data_odd(rd_odd), .i_dq(i_dq),
        .i_write_mask(i_write_mask), .o_rd_req(o_rd_req), .o_rd_bank(o_rd_bank), .o_rd_col_even(col_e),
        .o_rd_col_odd(col_o), .o_dq_even(o_dq_even), .o_dq_odd(o_dq_odd), .o_dq_oe(o_dq_oe),
        .o_wr_en(o_wr_en), .o_wr_bank(o_wr_bank), .o_wr_col(o_wr_col), .o_wr_data(o_wr_data),
        .o_bank_open(o_bank_open));

    ddr_array_model i_array (.i_strobe_clk(strobe_clk), .i_wr_en(o_wr_en), .i_wr_bank(o_wr_bank),
        .i_wr_col(o_wr_col), .i_wr_data(o_wr_data), .i_rd_bank(o_rd_bank), .i_rd_col_even(col_e),
        .i_rd_col_odd(col_o), .o_rd_even(rd_even), .o_rd_odd(rd_odd));

    // stored words as seen one strobe edge after each capture
    always @(posedge strobe_clk) begin
        if (o_wr_en === 1'b1) begin
            wq.push_back({o_wr_bank, o_wr_col, o_wr_data});
        end
    end

    task automatic print_verdict();
        $display("errors %0d, checks %0d", err_count, tests_run);
        if (err_count == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge i_mclk);
        #5;
    endtask

    task automatic issue(input cmd_e c, input logic [1:0] ba, input logic [11:0] a);
        i_cs_n = 1'b0;
        {i_ras_n, i_cas_n, i_we_n} = c;
        i_ba = ba;
        i_addr = a;
        cyc(1);
        i_cs_n = 1'b1;
        {i_ras_n, i_cas_n, i_we_n} = CMD_NOP;
    endtask

    // strobe runs only within a frame; word index is edge number minus four
    task automatic frame(input int n, input int mw, input int mx = 99);
        for (int e = 1; e <= n; e++) begin
            i_dq = 32'hC000_0000 + 32'(e - 4);
            i_write_mask = (e - 4 == mw) || (e - 4 >= mx);
            #15 strobe_clk = 1'b1;
            #15 strobe_clk = 1'b0;
        end
    endtask

    function automatic logic [7:0] bcol(input logic [7:0] s, input int i, input int bl, input logic il);
        logic [7:0] m;
        m = 8'(bl - 1);
        return (s & ~m) | ((il ? (s ^ 8'(i)) : (s + 8'(i))) & m);
    endfunction

    task automatic mode(input int bl, input logic il, input int c);
        bl_code = 3'($clog2(bl));
        mode_ilv = il;
        mode_cl = 2'(c);
    endtask

    task automatic burst(input logic [1:0] ba, input logic [7:0] col, input int bl, input logic il);
        for (int k = 0; k < bl / 2; k++) begin
            if (k > 0) cyc(1);
            check(o_dq_oe, 1);
            check(o_dq_even, shadow[{ba, bcol(col, 2 * k, bl, il)}]);
            check(o_dq_odd, shadow[{ba, bcol(col, 2 * k + 1, bl, il)}]);
        end
        cyc(1);
        check(o_dq_oe, 0);
    endtask

    task automatic rd(input logic [1:0] ba, input logic [7:0] col, input logic ap, input int bl,
                      input logic il, input int c);
        mode(bl, il, c);
        issue(CMD_READ, ba, {3'h0, ap, col});
        check(o_rd_req, 1);
        cyc(c);
        burst(ba, col, bl, il);
    endtask

    task automatic t_refuse();
        issue(CMD_READ, 2'h1, 12'h010);
        check(o_rd_req, 0);
        issue(CMD_ACT, 2'h0, 12'h000);
        issue(CMD_ACT, 2'h2, 12'h000);
        check(o_bank_open, 4'h5);
        {i_ras_n, i_cas_n, i_we_n} = CMD_READ;
        cyc(1);
        check(o_rd_req, 0);
        {i_ras_n, i_cas_n, i_we_n} = CMD_NOP;
        cyc(2);
        check(o_dq_oe, 0);
    endtask

    task automatic t_modes();
        int n;
        n = 0;
        for (int b = 0; b < 3; b++) begin
            for (int il = 0; il < 2; il++) begin
                for (int c = 2; c < 4; c++) begin
                    rd(2'h0, 8'h13 + 8'(n * 7), 1'b0, 2 << b, il[0], c);
                    n++;
                end
            end
        end
    endtask

    task automatic t_interrupt();
        mode(4, 1'b0, 2);
        issue(CMD_READ, 2'h0, 12'h005);
        issue(CMD_READ, 2'h0, 12'h03A);
        cyc(1);
        check(o_dq_even, shadow[{2'h0, 8'h05}]);
        check(o_dq_odd, shadow[{2'h0, 8'h06}]);
        cyc(1);
        burst(2'h0, 8'h3A, 4, 1'b0);
    endtask

    task automatic t_cut();
        cmd_e cuts [2];
        cuts = '{CMD_STOP, CMD_PRE};
        for (int i = 0; i < 2; i++) begin
            mode(8, 1'b0, 2);
            issue(CMD_READ, 2'h0, 12'h020);
            issue(cuts[i], 2'h0, 12'h000);
            cyc(1);
            check(o_dq_even, shadow[{2'h0, 8'h20}]);
            cyc(1);
            check(o_dq_oe, 0);
        end
        check(o_bank_open[0], 0);
        issue(CMD_ACT, 2'h0, 12'h000);
        check(o_bank_open[0], 1);
    endtask

    task automatic t_auto();
        rd(2'h2, 8'h04, 1'b1, 4, 1'b0, 2);
        check(o_bank_open[2], 0);
        issue(CMD_ACT, 2'h2, 12'h000);
        check(o_bank_open[2], 1);
    endtask

    task automatic t_write();
        logic [7:0] c;
        mode(4, 1'b0, 2);
        issue(CMD_WRITE, 2'h0, 12'h042);
        frame(10, 1);
        cyc(1);
        check(wq.size(), 3);
        for (int w = 0; w < 4; w++) begin
            c = bcol(8'h42, w, 4, 1'b0);
            if (w != 1 && wq.size() > 0) begin
                check(wq.pop_front(), {2'h0, c, 32'hC000_0000 + 32'(w)});
                shadow[{2'h0, c}] = 32'hC000_0000 + 32'(w);
            end
        end
        rd(2'h0, 8'h42, 1'b0, 4, 1'b0, 2);
    endtask

    // read two clocks into a write: words from the read on are masked
    task automatic t_wr_cut();
        mode(8, 1'b0, 2);
        issue(CMD_WRITE, 2'h0, 12'h080);
        for (int w = 0; w < 3; w++) begin
            shadow[{2'h0, 8'h80 + 8'(w)}] = 32'hC000_0000 + 32'(w);
        end
        fork
            frame(10, 3, 3);
            begin
                cyc(1);
                rd(2'h0, 8'h80, 1'b0, 8, 1'b0, 2);
            end
        join
        check(wq.size(), 3);
        wq.delete();
    endtask

    // clock enable holds the read pipe; then a precharge that keeps the burst
    task automatic t_freeze();
        mode(4, 1'b0, 2);
        issue(CMD_READ, 2'h2, 12'h010);
        ce = 1'b0;
        cyc(2);
        check({o_rd_req, o_dq_oe}, 2'h2);
        ce = 1'b1;
        cyc(1);
        issue(CMD_PRE, 2'h2, 12'h000);
        burst(2'h2, 8'h10, 4, 1'b0);
        check(o_bank_open[2], 0);
        issue(CMD_ACT, 2'h2, 12'h000);
        check(o_bank_open[2], 1);
    endtask

    initial begin
        for (int i = 0; i < 1024; i++) begin
            shadow[i] = 32'h5A00_0000 | 32'(i);
        end
        fork
            frame(4, -1);
            repeat (2) @(posedge i_mclk);
        join
        #5 i_reset = 1'b0;
        check({o_bank_open, o_dq_oe, o_rd_req, o_wr_en}, 0);
        t_refuse();
        t_modes();
        t_interrupt();
        t_cut();
        t_auto();
        t_write();
        t_wr_cut();
        t_freeze();
        print_verdict();
    end

    initial begin
        #500000;
        err_count++;
        print_verdict();
    end
endmodule

`default_nettype wire
